// ### design/isomc_defs.vh
// Register offsets, field positions, reset values and codes for the input select monitor.
`ifndef ISOMC_DEFS_VH
`define ISOMC_DEFS_VH

`define ISOMC_ADDR_SUMMARY 8'h01
`define ISOMC_ADDR_INSEL 8'h10
`define ISOMC_ADDR_AMP_ALARM 8'h11
`define ISOMC_ADDR_AUX_ERR 8'h12

`define ISOMC_INSEL_RESET 3'h5
`define ISOMC_SUMMARY_BIT 4
`define ISOMC_SECOND_CRC_ERROR_FLAG_BIT 0

`define ISOMC_SEL_B_A 3'h0
`define ISOMC_SEL_A_B 3'h1
`define ISOMC_SEL_B_COM 3'h2
`define ISOMC_SEL_A_COM 3'h3
`define ISOMC_SEL_HV 3'h4
`define ISOMC_SEL_MID 3'h5
`define ISOMC_SEL_TEMP 3'h6
`define ISOMC_SEL_RSVD 3'h7

`define ISOMC_ALARM_COUNT 8

`endif

// ### design/isomc_sticky.v
// Sticky flag bank where a set in the same cycle as a clear wins.
`timescale 1ns/1ps
module isomc_sticky #(
  parameter WIDTH = 1
) (
  clk, // System clock.
  nrst, // Asynchronous reset, active low.
  set, // Per-bit set request.
  clr, // Per-bit clear request.
  q_next, // Value the flags take at the next edge.
  q // Current flag value.
);
  input wire clk; // System clock.
  input wire nrst; // Reset, active low.
  input wire [WIDTH-1:0] set; // Set requests.
  input wire [WIDTH-1:0] clr; // Clear requests.
  output wire [WIDTH-1:0] q_next; // Next value.
  output reg [WIDTH-1:0] q; // Flags.

  // A pending event must never be lost to a read that lands on the same edge.
  assign q_next = set | (q & ~clr);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= {WIDTH{1'b0}};
    end
    else
    begin
      q <= q_next;
    end
  end
endmodule // isomc_sticky

// ### design/isomc_chan_decode.v
// Decoder from the channel select code to one-hot analog switch controls.
`timescale 1ns/1ps
`include "isomc_defs.vh"
module isomc_chan_decode (
  code, // Input channel select code.
  sel_b_a, // Input B positive against input A.
  sel_a_b, // Input A positive against input B.
  sel_b_com, // Input B against common.
  sel_a_com, // Input A against common.
  sel_hv, // Scaled high supply readback.
  sel_mid, // Amplifier inputs shorted to supply midpoint.
  sel_temp // Diode temperature sensor.
);
  input wire [2:0] code; // Channel code.
  output reg sel_b_a; // Switch control.
  output reg sel_a_b; // Switch control.
  output reg sel_b_com; // Switch control.
  output reg sel_a_com; // Switch control.
  output reg sel_hv; // Switch control.
  output reg sel_mid; // Switch control.
  output reg sel_temp; // Switch control.

  always @*
  begin
    sel_b_a = 1'b0;
    sel_a_b = 1'b0;
    sel_b_com = 1'b0;
    sel_a_com = 1'b0;
    sel_hv = 1'b0;
    sel_mid = 1'b0;
    sel_temp = 1'b0;
    case (code)
      `ISOMC_SEL_B_A: sel_b_a = 1'b1;
      `ISOMC_SEL_A_B: sel_a_b = 1'b1;
      `ISOMC_SEL_B_COM: sel_b_com = 1'b1;
      `ISOMC_SEL_A_COM: sel_a_com = 1'b1;
      `ISOMC_SEL_HV: sel_hv = 1'b1;
      `ISOMC_SEL_MID: sel_mid = 1'b1;
      `ISOMC_SEL_TEMP: sel_temp = 1'b1;
      // The reserved code opens every switch so no undefined path is formed.
      default: sel_b_a = 1'b0;
    endcase
  end
endmodule // isomc_chan_decode

// ### design/isomc_top.v
// Input channel selector and amplifier overload alarm logic with its register port.
`timescale 1ns/1ps
`include "isomc_defs.vh"
module isomc_top (
  clk, // System clock, 20 MHz.
  nrst, // Asynchronous reset, active low.
  reg_addr, // Register address from the serial port.
  reg_wdata, // Register write data.
  reg_wr, // Register write strobe, one cycle.
  reg_rd, // Register read strobe, one cycle.
  reg_rdata, // Register read data.
  reg_rvalid, // Read data valid, one cycle.
  amp_alarm_raw, // Comparator outputs of the eight headroom monitors.
  second_crc_error_flag_err_set, // Second CRC error event, one cycle.
  second_crc_error_flag_err_clr, // Second CRC error clear, one cycle.
  start_pin, // Conversion start pin level.
  start_cmd, // Start command decoded from the serial port, one cycle.
  continuous_mode, // High for continuous conversions, low for one-shot.
  input_channel_select, // Current channel select code.
  sel_b_a, // Switch: input B against input A.
  sel_a_b, // Switch: input A against input B.
  sel_b_com, // Switch: input B against common.
  sel_a_com, // Switch: input A against common.
  sel_hv, // Switch: scaled high supply readback.
  sel_mid, // Switch: inputs shorted to midpoint.
  sel_temp, // Switch: temperature sensor.
  amp_or_crc_summary_flag, // Summary flag for the conversion status byte.
  conv_start, // Conversion start, one cycle.
  conv_gate, // Continuous conversions allowed, level.
  channel_stale // Channel select register written since the last conversion start.
);
  input wire clk; // Clock.
  input wire nrst; // Reset.
  input wire [7:0] reg_addr; // Address.
  input wire [7:0] reg_wdata; // Write data.
  input wire reg_wr; // Write strobe.
  input wire reg_rd; // Read strobe.
  output reg [7:0] reg_rdata; // Read data.
  output reg reg_rvalid; // Read valid.
  input wire [7:0] amp_alarm_raw; // Comparators.
  input wire second_crc_error_flag_err_set; // SECOND_CRC_ERROR_FLAG event.
  input wire second_crc_error_flag_err_clr; // SECOND_CRC_ERROR_FLAG clear.
  input wire start_pin; // Start pin.
  input wire start_cmd; // Start command.
  input wire continuous_mode; // Conversion mode.
  output reg [2:0] input_channel_select; // Channel code.
  output reg sel_b_a; // Switch control.
  output reg sel_a_b; // Switch control.
  output reg sel_b_com; // Switch control.
  output reg sel_a_com; // Switch control.
  output reg sel_hv; // Switch control.
  output reg sel_mid; // Switch control.
  output reg sel_temp; // Switch control.
  output reg amp_or_crc_summary_flag; // Summary flag.
  output reg conv_start; // Start pulse.
  output reg conv_gate; // Run gate.
  output reg channel_stale; // Stale channel.

  reg [2:0] insel_reg;
  reg [2:0] insel_next;
  reg start_pin_reg;
  wire wr_insel;
  wire rd_alarm;
  wire [7:0] alarm_q;
  wire [7:0] alarm_next;
  wire [7:0] alarm_clr;
  wire second_crc_error_flag_q;
  wire second_crc_error_flag_next;
  wire summary_next;
  wire start_event;
  wire d_b_a;
  wire d_a_b;
  wire d_b_com;
  wire d_a_com;
  wire d_hv;
  wire d_mid;
  wire d_temp;
  reg [7:0] rdata_next;

  // Every access arrives here after the serial port has checked its CRC.
  assign wr_insel = reg_wr && (reg_addr == `ISOMC_ADDR_INSEL);
  assign rd_alarm = reg_rd && (reg_addr == `ISOMC_ADDR_AMP_ALARM);
  assign alarm_clr = {`ISOMC_ALARM_COUNT{rd_alarm}};

  always @*
  begin
    insel_next = insel_reg;
    if (wr_insel)
    begin
      insel_next = reg_wdata[2:0];
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      insel_reg <= `ISOMC_INSEL_RESET;
    end
    else
    begin
      insel_reg <= insel_next;
    end
  end

  // Decoding the next code keeps switch controls aligned with the stored field.
  isomc_chan_decode u_decode (
    .code(insel_next),
    .sel_b_a(d_b_a),
    .sel_a_b(d_a_b),
    .sel_b_com(d_b_com),
    .sel_a_com(d_a_com),
    .sel_hv(d_hv),
    .sel_mid(d_mid),
    .sel_temp(d_temp)
  );

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      input_channel_select <= `ISOMC_INSEL_RESET;
      sel_b_a <= 1'b0;
      sel_a_b <= 1'b0;
      sel_b_com <= 1'b0;
      sel_a_com <= 1'b0;
      sel_hv <= 1'b0;
      sel_mid <= 1'b1;
      sel_temp <= 1'b0;
    end
    else
    begin
      input_channel_select <= insel_next;
      sel_b_a <= d_b_a;
      sel_a_b <= d_a_b;
      sel_b_com <= d_b_com;
      sel_a_com <= d_a_com;
      sel_hv <= d_hv;
      sel_mid <= d_mid;
      sel_temp <= d_temp;
    end
  end

  // Comparators are sampled every clock, so any pulse of one clock or more is caught;
  // a pulse that falls wholly between two edges is a limitation of synchronous sampling.
  isomc_sticky #(
    .WIDTH(`ISOMC_ALARM_COUNT)
  ) u_alarm (
    .clk(clk),
    .nrst(nrst),
    .set(amp_alarm_raw),
    .clr(alarm_clr),
    .q_next(alarm_next),
    .q(alarm_q)
  );

  isomc_sticky #(
    .WIDTH(1)
  ) u_second_crc_error_flag (
    .clk(clk),
    .nrst(nrst),
    .set(second_crc_error_flag_err_set),
    .clr(second_crc_error_flag_err_clr),
    .q_next(second_crc_error_flag_next),
    .q(second_crc_error_flag_q)
  );

  // Built from next values so the flag changes on the same edge as its sources.
  assign summary_next = (|alarm_next) | second_crc_error_flag_next;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      amp_or_crc_summary_flag <= 1'b0;
    end
    else
    begin
      amp_or_crc_summary_flag <= summary_next;
    end
  end

  always @*
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      `ISOMC_ADDR_SUMMARY: rdata_next[`ISOMC_SUMMARY_BIT] = amp_or_crc_summary_flag;
      `ISOMC_ADDR_INSEL: rdata_next = {5'h00, insel_reg};
      `ISOMC_ADDR_AMP_ALARM: rdata_next = alarm_q;
      `ISOMC_ADDR_AUX_ERR: rdata_next[`ISOMC_SECOND_CRC_ERROR_FLAG_BIT] = second_crc_error_flag_q;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data is captured before the clear-on-read takes effect on the same edge.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= rdata_next;
      end
    end
  end

  assign start_event = start_cmd | (start_pin & ~start_pin_reg);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      start_pin_reg <= 1'b0;
      conv_start <= 1'b0;
      conv_gate <= 1'b0;
      channel_stale <= 1'b0;
    end
    else
    begin
      start_pin_reg <= start_pin;
      conv_start <= start_event;
      conv_gate <= start_pin & continuous_mode;
      // A write on the same edge as a start keeps the channel marked stale.
      channel_stale <= wr_insel | (channel_stale & ~start_event);
    end
  end
endmodule // isomc_top

// ### tb/isomc_assertions.sv
// Concurrent checks on the ports of the input select monitor.
`timescale 1ns/1ps
module isomc_assertions (
  input wire clk, // Clock.
  input wire nrst, // Reset, active low.
  input wire [7:0] reg_addr, // Address.
  input wire [7:0] reg_wdata, // Write data.
  input wire reg_wr, // Write strobe.
  input wire reg_rd, // Read strobe.
  input wire reg_rvalid, // Read valid.
  input wire [7:0] amp_alarm_raw, // Comparators.
  input wire second_crc_error_flag_err_set, // SECOND_CRC_ERROR_FLAG event.
  input wire second_crc_error_flag_err_clr, // SECOND_CRC_ERROR_FLAG clear.
  input wire start_pin, // Start pin.
  input wire start_cmd, // Start command.
  input wire [2:0] input_channel_select, // Code.
  input wire sel_b_a, // Switch.
  input wire sel_a_b, // Switch.
  input wire sel_b_com, // Switch.
  input wire sel_a_com, // Switch.
  input wire sel_hv, // Switch.
  input wire sel_mid, // Switch.
  input wire sel_temp, // Switch.
  input wire amp_or_crc_summary_flag, // Summary.
  input wire conv_start // Start pulse.
);
  wire [6:0] sel_vec;
  wire flag;
  assign sel_vec = {sel_temp, sel_mid, sel_hv, sel_a_com, sel_b_com, sel_a_b, sel_b_a};
  assign flag = amp_or_crc_summary_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_decode_onehot: assert property
    (sel_vec == ((input_channel_select == 3'h7) ? 7'h00 : 7'h01 << input_channel_select))
    else $error("switch controls disagree with code");
  a_code_write: assert property (reg_wr && reg_addr == 8'h10
    |=> input_channel_select == $past(reg_wdata[2:0])) else $error("code not stored");
  a_alarm_flag: assert property (|amp_alarm_raw |=> flag)
    else $error("alarm did not raise summary");
  a_crc_flag: assert property (second_crc_error_flag_err_set |=> flag)
    else $error("crc error did not raise summary");
  a_flag_holds: assert property (flag && !reg_rd && !second_crc_error_flag_err_clr |=> flag)
    else $error("summary fell without a clear");
  a_flag_quiet: assert property (!flag && !(|amp_alarm_raw) && !second_crc_error_flag_err_set |=> !flag)
    else $error("summary rose without a source");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_cmd_start: assert property (start_cmd |=> conv_start)
    else $error("command start missed");
  a_pin_start: assert property ($rose(start_pin) |=> conv_start)
    else $error("pin start missed");
  c_flag_fall: cover property ($fell(flag));
  c_temp_sel: cover property (sel_temp);
  c_start: cover property (conv_start);
endmodule // isomc_assertions

// ### tb/isomc_host_model.sv
// Host controller model that reaches the registers through the strobe port.
`timescale 1ns/1ps
module isomc_host_model (
  input wire clk, // Clock.
  input wire [7:0] reg_rdata, // Read data.
  input wire reg_rvalid, // Read valid.
  output reg [7:0] reg_addr, // Address.
  output reg [7:0] reg_wdata, // Write data.
  output reg reg_wr, // Write strobe.
  output reg reg_rd // Read strobe.
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Callers never pass the reserved code 111.
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  end
  endtask
  // Released lines are inverted so a stale value cannot pass for a live one.
  task rd(input [7:0] a, output [7:0] d, output ok);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  end
  endtask
endmodule // isomc_host_model

// ### tb/tb_input_select_and_overload_monitor.sv
// Testbench for the input select and overload monitor.
`timescale 1ns/1ps
module tb_input_select_and_overload_monitor;
  reg clk, nrst, second_crc_error_flag_err_set, second_crc_error_flag_err_clr, start_pin, start_cmd, continuous_mode;
  reg [7:0] amp_alarm_raw;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, sel_b_a, sel_a_b, sel_b_com, sel_a_com, sel_hv;
  wire sel_mid, sel_temp, amp_or_crc_summary_flag, conv_start, conv_gate, channel_stale;
  wire [2:0] input_channel_select;
  integer bad_count, samples_checked, cyc;
  isomc_top u_isomc_top (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .amp_alarm_raw(amp_alarm_raw), .second_crc_error_flag_err_set(second_crc_error_flag_err_set),
    .second_crc_error_flag_err_clr(second_crc_error_flag_err_clr), .start_pin(start_pin), .start_cmd(start_cmd),
    .continuous_mode(continuous_mode), .input_channel_select(input_channel_select),
    .sel_b_a(sel_b_a), .sel_a_b(sel_a_b), .sel_b_com(sel_b_com), .sel_a_com(sel_a_com),
    .sel_hv(sel_hv), .sel_mid(sel_mid), .sel_temp(sel_temp), .conv_start(conv_start),
    .amp_or_crc_summary_flag(amp_or_crc_summary_flag), .conv_gate(conv_gate),
    .channel_stale(channel_stale));
  isomc_host_model u_isomc_host_model (.clk(clk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      $display("wrong value %0s expected %h seen %h", nm, e, g);
      bad_count = bad_count + 1;
    end
  end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    reg [7:0] d;
    reg ok;
  begin
    u_isomc_host_model.rd(a, d, ok);
    chk("rvalid", 8'h01, {7'h00, ok});
    chk("rdata", e, d);
  end
  endtask
  task pulse_alarm(input [7:0] v);
  begin
    @(posedge clk);
    amp_alarm_raw <= v;
    @(posedge clk);
    amp_alarm_raw <= 8'h00;
    #1;
  end
  endtask
  task test_reset;
  begin
    chk("mid", 8'h01, {7'h00, sel_mid});
    chk("code", 8'h05, {5'h00, input_channel_select});
    rdchk(8'h10, 8'h05);
    rdchk(8'h20, 8'h00);
    $display("test reset done");
  end
  endtask
  task test_codes;
    integer c;
  begin
    for (c = 0; c < 7; c = c + 1)
    begin
      u_isomc_host_model.wr(8'h10, 8'hf8 | c[7:0]);
      chk("code", c[7:0], {5'h00, input_channel_select});
      chk("sel", 8'h01 << c, {1'b0, sel_temp, sel_mid, sel_hv, sel_a_com, sel_b_com,
        sel_a_b, sel_b_a});
      rdchk(8'h10, c[7:0]);
    end
    $display("test codes done");
  end
  endtask
  task test_alarm;
  begin
    pulse_alarm(8'h08);
    chk("flag", 8'h01, {7'h00, amp_or_crc_summary_flag});
    rdchk(8'h01, 8'h10);
    rdchk(8'h11, 8'h08);
    rdchk(8'h11, 8'h00);
    chk("flag", 8'h00, {7'h00, amp_or_crc_summary_flag});
    rdchk(8'h01, 8'h00);
    @(posedge clk);
    amp_alarm_raw <= 8'h80;
    rdchk(8'h11, 8'h80);
    rdchk(8'h11, 8'h80);
    @(posedge clk);
    amp_alarm_raw <= 8'h00;
    rdchk(8'h11, 8'h80);
    rdchk(8'h11, 8'h00);
    $display("test alarm done");
  end
  endtask
  task test_crc;
  begin
    @(posedge clk);
    second_crc_error_flag_err_set <= 1'b1;
    @(posedge clk);
    second_crc_error_flag_err_set <= 1'b0;
    rdchk(8'h12, 8'h01);
    pulse_alarm(8'h01);
    @(posedge clk);
    second_crc_error_flag_err_clr <= 1'b1;
    @(posedge clk);
    second_crc_error_flag_err_clr <= 1'b0;
    #1;
    chk("flag", 8'h01, {7'h00, amp_or_crc_summary_flag});
    rdchk(8'h12, 8'h00);
    rdchk(8'h11, 8'h01);
    chk("flag", 8'h00, {7'h00, amp_or_crc_summary_flag});
    $display("test crc done");
  end
  endtask
  task test_start;
  begin
    u_isomc_host_model.wr(8'h10, 8'h04);
    chk("stale", 8'h01, {7'h00, channel_stale});
    @(posedge clk);
    start_cmd <= 1'b1;
    @(posedge clk);
    start_cmd <= 1'b0;
    #1;
    chk("start", 8'h01, {7'h00, conv_start});
    chk("stale", 8'h00, {7'h00, channel_stale});
    @(posedge clk);
    start_pin <= 1'b1;
    continuous_mode <= 1'b1;
    @(posedge clk);
    #1;
    chk("start", 8'h01, {7'h00, conv_start});
    chk("gate", 8'h01, {7'h00, conv_gate});
    $display("test start done");
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  initial
  begin
    {nrst, second_crc_error_flag_err_set, second_crc_error_flag_err_clr, start_pin, start_cmd, continuous_mode} = 6'h00;
    amp_alarm_raw = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    test_reset;
    test_codes;
    test_alarm;
    test_crc;
    test_start;
    test_done;
  end
endmodule // tb_input_select_and_overload_monitor
bind isomc_top isomc_assertions u_isomc_assertions (.*);
